// File: design/dpm_defines.svh
// Offsets, field positions, reset values and widths of the dual-port memory.
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH
`define DPM_DATA_W     32
`define DPM_PAR_W      4
`define DPM_ADDR_W     15
`define DPM_IDX_HI     13
`define DPM_IDX_LO     5
`define DPM_IDX_W      9
`define DPM_DEPTH      512
`define DPM_ADDR_W_X1  14
`define DPM_ADDR_W_X36 9
`define DPM_CHAIN_BIT  14
`define DPM_APB_AW     12
`define DPM_CTRL_OFS   12'h000
`define DPM_PRE_A_OFS  12'h004
`define DPM_PRE_B_OFS  12'h008
`define DPM_STAT_OFS   12'h00c
`define DPM_CTRL_MASK  32'h0000ff7f
`define DPM_CTRL_RST   32'h00000000
`define DPM_PRE_RST    32'h00000000
`define DPM_MODE_A_LO  0
`define DPM_MODE_B_LO  2
`define DPM_REGM_A     4
`define DPM_REGM_B     5
`define DPM_CHAIN_EN   6
`define DPM_PAR_A_LO   8
`define DPM_PAR_B_LO   12
`define DPM_ST_WW      0
`define DPM_ST_FOLD    1
`define DPM_ST_RW      2
`endif

// File: design/dpm_pkg.sv
// Types shared by the dual-port memory modules.
package dpm_pkg;
   typedef enum logic [1:0] {
      DPM_WRITE_FIRST = 2'b00,
      DPM_READ_FIRST  = 2'b01,
      DPM_NO_CHANGE   = 2'b10
   } dpm_mode_type;
   typedef logic [35:0] dpm_word_type;
endpackage

// File: design/dpm_port_if.sv
// Signals between the memory top and one port's output engine.
interface dpm_port_if;
   logic                  en;
   logic                  we;
   logic                  preset;
   logic                  gate;
   logic                  regMode;
   dpm_pkg::dpm_mode_type mode;
   dpm_pkg::dpm_word_type wrWord;
   dpm_pkg::dpm_word_type rdOld;
   dpm_pkg::dpm_word_type presetVal;
   dpm_pkg::dpm_word_type latchWord;
   dpm_pkg::dpm_word_type outWord;
   modport core (output en, we, preset, gate, regMode, mode, wrWord, rdOld, presetVal,
                 input latchWord, outWord);
   modport engine (input en, we, preset, gate, regMode, mode, wrWord, rdOld, presetVal,
                   output latchWord, outWord);
endinterface

// File: design/dpm_port_engine.sv
// Output latch, read-during-write modes and optional pipeline stage of one port.
module dpm_port_engine (
   input wire logic    clk,
   input wire logic    sys_rst,
   dpm_port_if.engine  port
);
   dpm_pkg::dpm_word_type latchWord_r;
   dpm_pkg::dpm_word_type latchWord_nxt;
   dpm_pkg::dpm_word_type pipeWord_r;
   dpm_pkg::dpm_word_type pipeWord_nxt;
   logic                  writeCyc;

   // Latch source; a disabled port keeps its word and preset outranks read and write.
   assign writeCyc = port.en && !port.preset && port.we;
   assign latchWord_nxt = !port.en ? latchWord_r :
                          port.preset ? port.presetVal :
                          !port.we ? port.rdOld :
                          (port.mode == dpm_pkg::DPM_READ_FIRST) ? port.rdOld :
                          (port.mode == dpm_pkg::DPM_NO_CHANGE) ? latchWord_r :
                          port.wrWord;
   assign pipeWord_nxt = (port.regMode && port.gate) ? latchWord_r : pipeWord_r;

   // The latch is loaded on the same edge that registers the address.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latchWord_r <= 36'h0;
         pipeWord_r  <= 36'h0;
      end else begin
         latchWord_r <= latchWord_nxt;
         pipeWord_r  <= pipeWord_nxt;
      end
   end

   // The pipeline stage adds one cycle of latency in exchange for clock rate.
   assign port.latchWord = latchWord_r;
   assign port.outWord   = port.regMode ? pipeWord_r : latchWord_r;

   idle_hold_a : assert property (@(posedge clk) disable iff (sys_rst)
      !port.en |=> $stable(latchWord_r))
      else $error("Disabled port changed its output latch.");
   read_shows_a : assert property (@(posedge clk) disable iff (sys_rst)
      port.en && !port.preset && !port.we |=> latchWord_r == $past(port.rdOld))
      else $error("Read did not show the addressed word.");
   wf_echo_a : assert property (@(posedge clk) disable iff (sys_rst)
      writeCyc && port.mode == dpm_pkg::DPM_WRITE_FIRST |=> latchWord_r == $past(port.wrWord))
      else $error("Transparent write did not echo the new word.");
   rf_old_a : assert property (@(posedge clk) disable iff (sys_rst)
      writeCyc && port.mode == dpm_pkg::DPM_READ_FIRST |=> latchWord_r == $past(port.rdOld))
      else $error("Read-first write did not show the old word.");
   nc_hold_a : assert property (@(posedge clk) disable iff (sys_rst)
      writeCyc && port.mode == dpm_pkg::DPM_NO_CHANGE |=> $stable(latchWord_r))
      else $error("Hold-on-write changed the output latch.");
   preset_load_a : assert property (@(posedge clk) disable iff (sys_rst)
      port.en && port.preset |=> latchWord_r == $past(port.presetVal))
      else $error("Preset value was not loaded.");
   pipe_cap_a : assert property (@(posedge clk) disable iff (sys_rst)
      port.regMode && port.gate ##1 port.regMode |-> port.outWord == $past(latchWord_r))
      else $error("Pipeline stage did not capture the latch.");
endmodule

// File: design/dpm_block_memory.sv
// Dual-port block memory top: shared array, two port engines and APB configuration.

`include "dpm_defines.svh"

module dpm_block_memory (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic [`DPM_APB_AW-1:0]     paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output wire logic [31:0]                prdata,
   output wire logic                       pready,
   output wire logic                       pslverr,
   input  wire logic                       enableA,
   input  wire logic                       writeEnableA,
   input  wire logic [`DPM_ADDR_W-1:0]     addressA,
   input  wire logic [`DPM_DATA_W-1:0]     writeWordBusA,
   input  wire logic [`DPM_PAR_W-1:0]      writeCheckBitsA,
   input  wire logic                       outputPresetA,
   input  wire logic                       pipeStageGateA,
   input  wire logic                       chainInputA,
   output wire logic [`DPM_DATA_W-1:0]     readWordBusA,
   output wire logic [`DPM_PAR_W-1:0]      readCheckBitsA,
   output wire logic                       chainOutputA,
   input  wire logic                       enableB,
   input  wire logic                       writeEnableB,
   input  wire logic [`DPM_ADDR_W-1:0]     addressB,
   input  wire logic [`DPM_DATA_W-1:0]     writeWordBusB,
   input  wire logic [`DPM_PAR_W-1:0]      writeCheckBitsB,
   input  wire logic                       outputPresetB,
   input  wire logic                       pipeStageGateB,
   input  wire logic                       chainInputB,
   output wire logic [`DPM_DATA_W-1:0]     readWordBusB,
   output wire logic [`DPM_PAR_W-1:0]      readCheckBitsB,
   output wire logic                       chainOutputB
);

   // Shared storage; no reset, contents persist across sys_rst.
   dpm_pkg::dpm_word_type mem [`DPM_DEPTH];

   // Configuration and status registers.
   logic [31:0]           ctrl_r;
   logic [31:0]           presetA_r;
   logic [31:0]           presetB_r;
   logic                  wwSeen_r;
   logic                  wwSeen_nxt;
   logic                  rwSeen_r;
   logic                  rwSeen_nxt;

   // Per-port views gathered so that the port logic is one loop.
   logic                  portEn       [2];
   logic                  portWe       [2];
   logic                  portPre      [2];
   logic                  portGate     [2];
   logic                  portChainIn  [2];

   // Address, words and configuration of each port.
   logic [`DPM_ADDR_W-1:0] portAddr    [2];
   dpm_pkg::dpm_word_type portWrWord   [2];
   dpm_pkg::dpm_word_type portPreVal   [2];
   dpm_pkg::dpm_mode_type portModeRaw  [2];
   dpm_pkg::dpm_mode_type portMode     [2];
   logic                  portRegMode  [2];

   // Decoded access and output of each port.
   logic [`DPM_IDX_W-1:0] portIdx      [2];
   dpm_pkg::dpm_word_type portRdOld    [2];
   dpm_pkg::dpm_word_type portLatch    [2];
   dpm_pkg::dpm_word_type portOut      [2];
   logic                  portWrite    [2];
   logic                  portRead     [2];
   logic                  portFold     [2];
   logic                  chainSel_r   [2];
   logic                  chainSel_nxt [2];
   logic [31:0]           portData     [2];

   // Configuration fields of the control register.
   logic                  chainMode;
   logic [1:0]            modeFieldA;
   logic [1:0]            modeFieldB;

   // APB decode, status word and clash watch.
   logic                  apbAccess;
   logic                  apbWrite;
   logic                  hitCtrl;
   logic                  hitPreA;
   logic                  hitPreB;
   logic                  hitStat;
   logic                  unmapped;
   logic [31:0]           statusWord;
   logic                  sameIdx;
   logic                  wwClash;
   logic                  rwClash;

   dpm_port_if portIf [2] ();

   // Gather the pins of both ports into indexed views.
   assign portEn[0]      = enableA;
   assign portEn[1]      = enableB;
   assign portWe[0]      = writeEnableA;
   assign portWe[1]      = writeEnableB;
   assign portPre[0]     = outputPresetA;
   assign portPre[1]     = outputPresetB;
   assign portGate[0]    = pipeStageGateA;
   assign portGate[1]    = pipeStageGateB;
   assign portChainIn[0] = chainInputA;
   assign portChainIn[1] = chainInputB;
   assign portAddr[0]    = addressA;
   assign portAddr[1]    = addressB;

   // Check bits ride above the data word.
   assign portWrWord[0]  = {writeCheckBitsA, writeWordBusA};
   assign portWrWord[1]  = {writeCheckBitsB, writeWordBusB};

   // Configuration fields taken from the control register.
   assign chainMode      = ctrl_r[`DPM_CHAIN_EN];
   assign modeFieldA     = ctrl_r[`DPM_MODE_A_LO +: 2];
   assign modeFieldB     = ctrl_r[`DPM_MODE_B_LO +: 2];
   assign portModeRaw[0] = dpm_pkg::dpm_mode_type'(modeFieldA);
   assign portModeRaw[1] = dpm_pkg::dpm_mode_type'(modeFieldB);
   assign portRegMode[0] = ctrl_r[`DPM_REGM_A];
   assign portRegMode[1] = ctrl_r[`DPM_REGM_B];

   // Preset words take their check bits from the control register.
   assign portPreVal[0]  = {ctrl_r[`DPM_PAR_A_LO +: 4], presetA_r};
   assign portPreVal[1]  = {ctrl_r[`DPM_PAR_B_LO +: 4], presetB_r};

   // Per-port address decode, mode resolution and chain selection.
   for (genvar i = 0; i < 2; i++) begin : g_port
      // The x36 word index sits in address bits 13 to 5; lower bits are ignored.
      assign portIdx[i]   = portAddr[i][`DPM_IDX_HI:`DPM_IDX_LO];
      assign portRdOld[i] = mem[portIdx[i]];

      // In chain mode this block holds the lower half; upper-half writes belong to the neighbour.
      assign portWrite[i] = portEn[i] && portWe[i]
                            && !(chainMode && portAddr[i][`DPM_CHAIN_BIT]);
      assign portRead[i]  = portEn[i] && !portWe[i] && !portPre[i];

      // Hold mode is folded to transparent in chain mode; undefined codes act as transparent.
      assign portFold[i]  = chainMode && (portModeRaw[i] == dpm_pkg::DPM_NO_CHANGE);
      always_comb begin
         case (portModeRaw[i])
            dpm_pkg::DPM_WRITE_FIRST: portMode[i] = dpm_pkg::DPM_WRITE_FIRST;
            dpm_pkg::DPM_READ_FIRST:  portMode[i] = dpm_pkg::DPM_READ_FIRST;
            dpm_pkg::DPM_NO_CHANGE:   portMode[i] = portFold[i] ? dpm_pkg::DPM_WRITE_FIRST
                                                                : dpm_pkg::DPM_NO_CHANGE;
            default:                  portMode[i] = dpm_pkg::DPM_WRITE_FIRST;
         endcase
      end

      // Remember which half served the last read so bit 0 follows the right block while the pipeline stage is off.
      assign chainSel_nxt[i] = (portRead[i] && chainMode) ? portAddr[i][`DPM_CHAIN_BIT]
                             : (portEn[i] ? 1'b0 : chainSel_r[i]);

      // The select is a flop, so bit 0 follows the latched word, not the live address.
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            chainSel_r[i] <= 1'b0;
         end else begin
            chainSel_r[i] <= chainSel_nxt[i];
         end
      end

      // Hand the request to the engine and take its output back.
      assign portIf[i].en        = portEn[i];
      assign portIf[i].we        = portWe[i];
      assign portIf[i].preset    = portPre[i];
      assign portIf[i].gate      = portGate[i];
      assign portIf[i].regMode   = portRegMode[i];
      assign portIf[i].mode      = portMode[i];
      assign portIf[i].wrWord    = portWrWord[i];
      assign portIf[i].rdOld     = portRdOld[i];
      assign portIf[i].presetVal = portPreVal[i];
      assign portLatch[i]        = portIf[i].latchWord;
      assign portOut[i]          = portIf[i].outWord;
      assign portData[i] = {portOut[i][31:1],
                            chainSel_r[i] ? portChainIn[i] : portOut[i][0]};

      // One engine per port, both on the shared clock.
      dpm_port_engine u_engine (
         .clk     (clk),
         .sys_rst (sys_rst),
         .port    (portIf[i])
      );
   end

   // Both ports write the array on the same edge; no arbitration, B lands last on a clash.
   // A preset never blocks the array write; it only loads the latch.
   always_ff @(posedge clk) begin
      if (portWrite[0]) begin
         mem[portIdx[0]] <= portWrWord[0];
      end
      if (portWrite[1]) begin
         mem[portIdx[1]] <= portWrWord[1];
      end
   end

   // Outputs: data from the port engines, check bits in the top four bits.
   assign readWordBusA   = portData[0];
   assign readWordBusB   = portData[1];
   assign readCheckBitsA = portOut[0][35:32];
   assign readCheckBitsB = portOut[1][35:32];
   assign chainOutputA   = portOut[0][0];
   assign chainOutputB   = portOut[1][0];

   // Clash watch: only flagged, never resolved, since the array cannot arbitrate.
   assign sameIdx = portIdx[0] == portIdx[1];
   assign wwClash = portWrite[0] && portWrite[1] && sameIdx
                    && (portWrWord[0] != portWrWord[1]);

   // Reads always get the old word here; the flag only marks the user's risk.
   assign rwClash = sameIdx && ((portWrite[0] && portRead[1]
                    && portMode[0] != dpm_pkg::DPM_READ_FIRST)
                    || (portWrite[1] && portRead[0]
                    && portMode[1] != dpm_pkg::DPM_READ_FIRST));

   // APB slave: zero wait states, error on any unmapped word.
   assign apbAccess = psel && penable;
   assign apbWrite  = apbAccess && pwrite;
   assign hitCtrl   = paddr == `DPM_CTRL_OFS;
   assign hitPreA   = paddr == `DPM_PRE_A_OFS;
   assign hitPreB   = paddr == `DPM_PRE_B_OFS;
   assign hitStat   = paddr == `DPM_STAT_OFS;
   assign unmapped  = !(hitCtrl || hitPreA || hitPreB || hitStat);
   assign pready    = 1'b1;
   assign pslverr   = apbAccess && unmapped;

   // Read data is a plain mux, so a read has no side effect.
   assign statusWord = {29'h0, rwSeen_r, portFold[0] || portFold[1], wwSeen_r};
   assign prdata    = hitCtrl ? ctrl_r :
                      hitPreA ? presetA_r :
                      hitPreB ? presetB_r :
                      hitStat ? statusWord : 32'h0;

   // Sticky flags: a new clash in the clearing cycle wins over the write-one-to-clear.
   assign wwSeen_nxt = wwClash || (wwSeen_r
                       && !(apbWrite && hitStat && pwdata[`DPM_ST_WW]));
   assign rwSeen_nxt = rwClash || (rwSeen_r
                       && !(apbWrite && hitStat && pwdata[`DPM_ST_RW]));

   // Control register; unused bits are masked so that they read back as zero.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= `DPM_CTRL_RST;
      end else if (apbWrite && hitCtrl) begin
         ctrl_r <= pwdata & `DPM_CTRL_MASK;
      end
   end

   // Preset word of port A.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presetA_r <= `DPM_PRE_RST;
      end else if (apbWrite && hitPreA) begin
         presetA_r <= pwdata;
      end
   end

   // Preset word of port B.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presetB_r <= `DPM_PRE_RST;
      end else if (apbWrite && hitPreB) begin
         presetB_r <= pwdata;
      end
   end

   // Sticky clash flags.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wwSeen_r <= 1'b0;
         rwSeen_r <= 1'b0;
      end else begin
         wwSeen_r <= wwSeen_nxt;
         rwSeen_r <= rwSeen_nxt;
      end
   end

   // Checks of the array, the ports and the register file.
   arr_write_a : assert property (@(posedge clk) disable iff (sys_rst)
      portWrite[0] && !(portWrite[1] && sameIdx)
      |=> mem[$past(portIdx[0])] == $past(portWrWord[0]))
      else $error("Port A write did not reach the array.");

   dual_read_a : assert property (@(posedge clk) disable iff (sys_rst)
      portRead[0] && portRead[1] && sameIdx
      |=> portLatch[0] == portLatch[1] && portLatch[0] == $past(portRdOld[0]))
      else $error("Simultaneous reads disagree.");

   old_read_a : assert property (@(posedge clk) disable iff (sys_rst)
      portWrite[0] && portRead[1] && sameIdx |=> portLatch[1] == $past(portRdOld[0]))
      else $error("Cross-port read did not return the old word.");

   chain_fold_a : assert property (@(posedge clk) disable iff (sys_rst)
      chainMode |-> portMode[0] != dpm_pkg::DPM_NO_CHANGE
                    && portMode[1] != dpm_pkg::DPM_NO_CHANGE)
      else $error("Hold mode active in chain configuration.");

   clash_flag_a : assert property (@(posedge clk) disable iff (sys_rst)
      wwClash |=> wwSeen_r [*2])
      else $error("Write clash was not recorded.");

   ctrl_write_a : assert property (@(posedge clk) disable iff (sys_rst)
      apbWrite && hitCtrl |=> ctrl_r == ($past(pwdata) & `DPM_CTRL_MASK))
      else $error("Control write did not take effect.");

   apb_err_a : assert property (@(posedge clk) disable iff (sys_rst)
      apbAccess |-> pslverr == unmapped && pready)
      else $error("APB answer does not match the decode.");

   b_write_a : assert property (@(posedge clk) disable iff (sys_rst)
      portWrite[1] |=> mem[$past(portIdx[1])] == $past(portWrWord[1]))
      else $error("Port B write did not reach the array.");

   preset_keep_a : assert property (@(posedge clk) disable iff (sys_rst)
      portEn[1] && portPre[1] && !portWe[1] && !portWrite[0]
      |=> mem[$past(portIdx[1])] == $past(portRdOld[1]))
      else $error("Preset disturbed the array.");

   rw_flag_a : assert property (@(posedge clk) disable iff (sys_rst)
      rwClash |=> rwSeen_r)
      else $error("Read clash was not recorded.");
endmodule

// File: verif/dpm_port_driver.sv
// Fabric-side driver of one memory port, standing in for the user logic in front of it.
module dpm_port_driver (
   input  wire logic        clk,
   output logic             enable,
   output logic             writeEnable,
   output logic [14:0]      address,
   output logic [31:0]      wordBus,
   output logic [3:0]       checkBits,
   output logic             preset,
   output logic             gate,
   output logic             chainIn
);
   timeunit 1ns;
   timeprecision 1ns;

   // Quiet state at time zero, so the port sees no request while reset is held.
   initial begin
      enable      = 1'b0;
      writeEnable = 1'b0;
      address     = '0;
      wordBus     = '0;
      checkBits   = '0;
      preset      = 1'b0;
      gate        = 1'b0;
      chainIn     = 1'b0;
   end

   // The neighbour bit toggles every cycle, so a stale chain value never looks right.
   always @(posedge clk) chainIn <= ~chainIn;

   // One request is launched just after an edge; both ports share the clock.
   task automatic put(input bit en, we, pre, gt, input logic [14:0] a, input logic [35:0] w);
      enable               <= en;
      writeEnable          <= we;
      preset               <= pre;
      gate                 <= gt;
      address              <= a;
      {checkBits, wordBus} <= w;
   endtask

   // Release the port; address and data flip, so a held value can never pass for a stale one.
   task automatic idle();
      enable               <= 1'b0;
      writeEnable          <= 1'b0;
      preset               <= 1'b0;
      gate                 <= 1'b0;
      address              <= ~address;
      {checkBits, wordBus} <= ~{checkBits, wordBus};
   endtask
endmodule

// File: verif/tb_dpm_block_memory.sv
// Self-checking bench of the dual-port memory against a reference model, with APB set-up.
`include "dpm_defines.svh"
module tb_dpm_block_memory;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {bit en; bit we; bit pre; bit gt; logic [14:0] a; logic [35:0] w;} dpm_req_type;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, errv;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv, rnd = 32'h74fe6f74, readWordBusA, readWordBusB;
   logic [31:0] writeWordBusA, writeWordBusB;
   logic [3:0]  writeCheckBitsA, writeCheckBitsB, readCheckBitsA, readCheckBitsB;
   logic enableA, writeEnableA, outputPresetA, pipeStageGateA, chainInputA, chainOutputA;
   logic enableB, writeEnableB, outputPresetB, pipeStageGateB, chainInputB, chainOutputB;
   logic [14:0] addressA, addressB;
   logic [35:0] mem [512], latch [2] = '{36'h0, 36'h0}, outv [2] = '{36'h0, 36'h0}, pv [2] = '{36'h0, 36'h0};
   int mode [2], pipe [2], chain, i, j, cyc = 0, n_errors = 0, num_checks = 0;

   dpm_block_memory i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enableA(enableA), .writeEnableA(writeEnableA), .addressA(addressA), .writeWordBusA(writeWordBusA),
      .writeCheckBitsA(writeCheckBitsA), .outputPresetA(outputPresetA), .pipeStageGateA(pipeStageGateA),
      .chainInputA(chainInputA), .readWordBusA(readWordBusA), .readCheckBitsA(readCheckBitsA),
      .chainOutputA(chainOutputA), .enableB(enableB), .writeEnableB(writeEnableB), .addressB(addressB),
      .writeWordBusB(writeWordBusB), .writeCheckBitsB(writeCheckBitsB), .outputPresetB(outputPresetB),
      .pipeStageGateB(pipeStageGateB), .chainInputB(chainInputB), .readWordBusB(readWordBusB),
      .readCheckBitsB(readCheckBitsB), .chainOutputB(chainOutputB));
   dpm_port_driver i_drvA (.clk(clk), .enable(enableA), .writeEnable(writeEnableA), .address(addressA),
      .wordBus(writeWordBusA), .checkBits(writeCheckBitsA), .preset(outputPresetA), .gate(pipeStageGateA),
      .chainIn(chainInputA));
   dpm_port_driver i_drvB (.clk(clk), .enable(enableB), .writeEnable(writeEnableB), .address(addressB),
      .wordBus(writeWordBusB), .checkBits(writeCheckBitsB), .preset(outputPresetB), .gate(pipeStageGateB),
      .chainIn(chainInputB));

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Random words come from a Galois-free shift register, so every run is the same.
   function automatic logic [35:0] nw();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      return {rnd[7:4], rnd};
   endfunction

   // The low five address bits are ignored by the port, so they carry noise on purpose.
   function automatic dpm_req_type rqm(input bit en, we, pre, gt, input int idx, input logic [35:0] w);
      return '{en, we, pre, gt, {1'b0, idx[8:0], rnd[4:0]}, w};
   endfunction

   // Single comparison point; every check is counted.
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Closing report and verdict.
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // APB transfer: setup, then access held until pready is seen high at an edge.
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register read with expected data and error response.
   task automatic reg_rd(input logic [11:0] a, input logic [31:0] e, input bit er);
      apb(1'b0, a, 32'h0);
      chk("prdata", {4'h0, e}, {4'h0, rdv});
      chk("pslverr", {35'h0, er}, {35'h0, errv});
   endtask

   // Mode, pipeline and chain set-up; the model follows the same settings.
   task automatic cfg(input int mA, mB, pA, pB, ch);
      mode = '{mA, mB};
      pipe = '{pA, pB};
      chain = ch;
      apb(1'b1, `DPM_CTRL_OFS, 32'(mA | mB << 2 | pA << 4 | pB << 5 | ch << 6) | {16'h0, pv[1][35:32],
          pv[0][35:32], 8'h0});
   endtask

   // One edge on both ports, then the model predicts both outputs from the old array contents.
   task automatic op(input dpm_req_type a, input dpm_req_type b);
      dpm_req_type r [2];
      logic [35:0] old [2], lo [2];
      int m;
      r = '{a, b};
      @(posedge clk);
      i_drvA.put(a.en, a.we, a.pre, a.gt, a.a, a.w);
      i_drvB.put(b.en, b.we, b.pre, b.gt, b.a, b.w);
      @(posedge clk);
      i_drvA.idle();
      i_drvB.idle();
      for (int p = 0; p < 2; p++) begin
         old[p] = mem[r[p].a[13:5]];
         lo[p] = latch[p];
         m = (mode[p] == 3 || (mode[p] == 2 && chain != 0)) ? 0 : mode[p];
         if (r[p].en && r[p].pre) latch[p] = pv[p];
         else if (r[p].en && !r[p].we) latch[p] = old[p];
         else if (r[p].en && m == 0) latch[p] = r[p].w;
         else if (r[p].en && m == 1) latch[p] = old[p];
         if (pipe[p] == 0) outv[p] = latch[p];
         else if (r[p].gt) outv[p] = lo[p];
      end
      for (int p = 0; p < 2; p++) if (r[p].en && r[p].we) mem[r[p].a[13:5]] = r[p].w;
      #1;
      chk("portA", outv[0], {readCheckBitsA, readWordBusA});
      chk("portB", outv[1], {readCheckBitsB, readWordBusB});
      chk("chainA", {35'h0, outv[0][0]}, {35'h0, chainOutputA});
      chk("chainB", {35'h0, outv[1][0]}, {35'h0, chainOutputB});
   endtask

   // Hang guard: the whole sequence needs well under this many cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         print_verdict();
      end
   end

   // Main sequence.
   initial begin
      mode = '{0, 0};
      pipe = '{0, 0};
      chain = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      reg_rd(`DPM_CTRL_OFS, `DPM_CTRL_RST, 1'b0);
      reg_rd(`DPM_PRE_A_OFS, `DPM_PRE_RST, 1'b0);
      reg_rd(12'h010, 32'h0, 1'b1);
      apb(1'b1, `DPM_CTRL_OFS, 32'hffffffff);
      reg_rd(`DPM_CTRL_OFS, `DPM_CTRL_MASK, 1'b0);
      cfg(0, 0, 0, 0, 0);
      for (int k = 0; k < 256; k++) op(rqm(1, 1, 0, 0, k, nw()), rqm(1, 1, 0, 0, k + 256, nw()));
      for (int md = 0; md < 5; md++) begin
         i = md == 4 ? 3 : md == 3 ? 2 : md;  // Code 3 must act as transparent.
         cfg(i, i, 0, 0, md == 3);
         if (md == 3) reg_rd(`DPM_STAT_OFS, 32'h1 << `DPM_ST_RW | 32'h1 << `DPM_ST_FOLD, 1'b0);
         for (int k = 0; k < 3; k++) begin
            i = int'(nw() & 36'hff);
            j = i + 256;  // Distinct indices: never two writers on one word at once.
            op(rqm(1, 1, 0, 0, i, nw()), rqm(1, 0, 0, 0, i, 36'h0));
            op(rqm(0, 1, 0, 0, j, nw()), rqm(1, 1, 0, 0, j, nw()));
            op(rqm(1, 0, 0, 0, j, 36'h0), rqm(1, 0, 0, 0, j, 36'h0));
            op(rqm(1, 1, 0, 0, j, nw()), rqm(1, 1, 0, 0, i, nw()));
         end
      end
      reg_rd(`DPM_STAT_OFS, 32'h1 << `DPM_ST_RW, 1'b0);
      apb(1'b1, `DPM_STAT_OFS, 32'hffffffff);
      reg_rd(`DPM_STAT_OFS, 32'h0, 1'b0);
      pv[0] = nw();
      pv[1] = nw();
      apb(1'b1, `DPM_PRE_A_OFS, pv[0][31:0]);
      apb(1'b1, `DPM_PRE_B_OFS, pv[1][31:0]);
      cfg(1, 0, 0, 0, 0);
      reg_rd(`DPM_PRE_B_OFS, pv[1][31:0], 1'b0);
      op(rqm(1, 1, 1, 0, 5, nw()), rqm(0, 0, 1, 0, 6, 36'h0));
      op(rqm(1, 0, 0, 0, 5, 36'h0), rqm(1, 0, 1, 0, 5, 36'h0));
      cfg(0, 1, 1, 1, 0);
      op(rqm(1, 0, 0, 1, 7, 36'h0), rqm(1, 1, 0, 1, 7, nw()));
      op(rqm(0, 0, 0, 1, 7, 36'h0), rqm(1, 0, 0, 1, 8, 36'h0));
      op(rqm(1, 0, 0, 0, 8, 36'h0), rqm(0, 0, 0, 0, 8, 36'h0));
      print_verdict();
   end
endmodule
